// [hw/acs_clkdiv.sv]
// converter clock divider: one tick every 2**sel system clocks
`timescale 1ns/1ps
module acs_clkdiv #(
  parameter int SEL_W = 3
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst,   // synchronous reset
  input  wire logic             run,   // divider runs while high
  input  wire logic [SEL_W-1:0] sel,   // divide ratio code
  output logic                  tick   // one-cycle converter clock strobe
);
  localparam int CW = (1 << SEL_W) - 1;

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] mask;
  logic          next_tick;

  // count while running, strobe when the selected low bits are all ones
  always_comb begin
    mask      = ~({CW{1'b1}} << sel);
    next_cnt  = run ? cnt + {{(CW-1){1'b0}}, 1'b1} : '0;
    next_tick = run && ((cnt & mask) == mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// [hw/acs_params.svh]
// offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ACS_OFF_CTRL_A   8'h00
`define ACS_OFF_CTRL_B   8'h04
`define ACS_OFF_RES_LO   8'h08
`define ACS_OFF_RES_HI   8'h0C
`define ACS_OFF_PIN_FSEL 8'h10
`define ACS_OFF_INT      8'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define ACS_INT_FLAG   0
`define ACS_INT_EN     1
`define ACS_INT_GEN    2
`define ACS_CTRL_RST   8'h00
`define ACS_PIN_RST    4'h0
`define ACS_EXT_PINS   4'h4

// ----------------------------------------------------------------
// conversion timing in converter clocks
// ----------------------------------------------------------------
`define ACS_SAMPLE_CLKS 4'h4
`define ACS_CONV_CLKS   4'hC

`endif

// [hw/acs_pkg.sv]
// types shared by the conversion sequencer files
package acs_pkg;

  // first control register layout
  typedef struct packed {
    logic       start;
    logic       busy;
    logic       enable;
    logic       justify;
    logic [3:0] chan;
  } ctrl_a_t;

  // second control register layout
  typedef struct packed {
    logic [2:0] in_sel;
    logic [1:0] ref_sel;
    logic [2:0] clk_sel;
  } ctrl_b_t;

  // one-hot switch controls toward the analog core
  typedef struct packed {
    logic [2:0] ref_sel;   // [0] ext pin, [1] supply, [2] dac reference
    logic [3:0] ext_sel;   // external analog pins 0..3
    logic [3:0] int_sel;   // amp a, amp b, amp c, dac output
  } route_t;

  typedef enum logic [1:0] {
    ACS_IDLE    = 2'b00,
    ACS_SAMPLE  = 2'b01,
    ACS_CONVERT = 2'b10
  } state_t;

endpackage

// [hw/acs_route.sv]
// decodes reference, input source and channel fields into switch controls
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_route (
  input  wire logic [1:0]    ref_code,   // reference select field
  input  wire logic [2:0]    src_code,   // input source field
  input  wire logic [3:0]    chan_code,  // external channel field
  output acs_pkg::route_t    route       // one-hot switch controls
);
  // pick one switch per group; unused ref and source codes fall back to the ext pin, no ext switch for channels above 3
  always_comb begin
    route = '0;
    unique case (ref_code)
      2'h1:    route.ref_sel = 3'h2;
      2'h2:    route.ref_sel = 3'h4;
      default: route.ref_sel = 3'h1;
    endcase
    unique case (src_code)
      3'h1:    route.int_sel = 4'h1;
      3'h2:    route.int_sel = 4'h2;
      3'h3:    route.int_sel = 4'h4;
      3'h4:    route.int_sel = 4'h8;
      default: route.ext_sel = (chan_code < `ACS_EXT_PINS) ? (4'h1 << chan_code[1:0]) : 4'h0;
    endcase
  end
endmodule

// [hw/acs_top.sv]
// conversion sequencer with apb register slave and pin function control
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              CLK,           // system clock
  input  wire logic              RST,           // synchronous reset
  input  wire logic              PSEL,          // apb select
  input  wire logic              PENABLE,       // apb access phase
  input  wire logic              PWRITE,        // apb direction
  input  wire logic [ADDR_W-1:0] PADDR,         // apb byte address
  input  wire logic [31:0]       PWDATA,        // apb write data
  output logic      [31:0]       PRDATA,        // apb read data
  output logic                   PREADY,        // apb ready
  output logic                   PSLVERR,       // apb unmapped address
  input  wire logic [11:0]       ADC_DATA,      // result from analog core
  output logic                   ADC_PWR,       // analog power on
  output logic                   ADC_RST,       // analog core reset
  output logic                   ADC_CLK_TICK,  // converter clock strobe
  output logic                   ADC_SAMPLE,    // sampling phase
  output logic                   ADC_CONVERT,   // converting phase
  output logic      [2:0]        REF_SEL,       // reference switches
  output logic      [3:0]        EXT_SEL,       // external pin switches
  output logic      [3:0]        INT_SEL,       // internal source switches
  input  wire logic [3:0]        PIN_PULL_REQ,  // programmed pull-highs
  input  wire logic [3:0]        PIN_OE_REQ,    // port direction outputs
  output logic      [3:0]        PIN_ANALOG,    // pin in analog role
  output logic      [3:0]        PIN_PULL_EN,   // pull-high actually on
  output logic      [3:0]        PIN_OE,        // pin output driver on
  output logic                   IRQ            // conversion interrupt
);
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // places the 12-bit result into the high and low byte pair
  function automatic logic [15:0] fmt(input logic [11:0] res, input logic right);
    fmt = right ? {4'h0, res} : {res, 4'h0};
  endfunction

  // true when the address is one of the mapped word offsets
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[7:0] == `ACS_OFF_CTRL_A) || (a[7:0] == `ACS_OFF_CTRL_B) ||
             (a[7:0] == `ACS_OFF_RES_LO) || (a[7:0] == `ACS_OFF_RES_HI) ||
             (a[7:0] == `ACS_OFF_PIN_FSEL) || (a[7:0] == `ACS_OFF_INT);
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  acs_pkg::ctrl_a_t ctrl_a;
  acs_pkg::ctrl_a_t next_ctrl_a;
  acs_pkg::ctrl_b_t ctrl_b;
  acs_pkg::ctrl_b_t next_ctrl_b;
  acs_pkg::state_t  state;
  acs_pkg::state_t  next_state;
  acs_pkg::route_t  route;
  logic [3:0]       pin_fsel;
  logic [3:0]       next_pin_fsel;
  logic [2:0]       int_ctl;
  logic [2:0]       next_int_ctl;
  logic [3:0]       cnt;
  logic [3:0]       next_cnt;
  logic             armed;
  logic             next_armed;
  logic             pend;
  logic             next_pend;
  logic             busy;
  logic [11:0]      result;
  logic [11:0]      next_result;
  logic             conv_done;
  logic             tick;
  logic             wr_en;
  logic [15:0]      res_pair;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;

  assign wr_en    = PSEL && PENABLE && PWRITE && PREADY;
  assign res_pair = fmt(result, ctrl_a.justify);

  // ----------------------------------------------------------------
  // converter clock and input routing
  // ----------------------------------------------------------------
  acs_clkdiv #(
    .SEL_W (3)
  ) u_div (
    .clk  (CLK),
    .rst  (RST),
    .run  (ctrl_a.enable && !ctrl_a.start),
    .sel  (ctrl_b.clk_sel),
    .tick (tick)
  );

  acs_route u_route (
    .ref_code  (ctrl_b.ref_sel),
    .src_code  (ctrl_b.in_sel),
    .chan_code (ctrl_a.chan),
    .route     (route)
  );

  // ----------------------------------------------------------------
  // apb register writes
  // ----------------------------------------------------------------
  // software fields; busy is read only, the request flag set wins
  always_comb begin
    next_ctrl_a      = ctrl_a;
    next_ctrl_b      = ctrl_b;
    next_pin_fsel    = pin_fsel;
    next_int_ctl     = int_ctl;
    next_ctrl_a.busy = 1'b0;
    if (wr_en) begin
      unique case (PADDR[7:0])
        `ACS_OFF_CTRL_A: begin
          next_ctrl_a      = acs_pkg::ctrl_a_t'(PWDATA[7:0]);
          next_ctrl_a.busy = 1'b0;
        end
        `ACS_OFF_CTRL_B:   next_ctrl_b   = acs_pkg::ctrl_b_t'(PWDATA[7:0]);
        `ACS_OFF_PIN_FSEL: next_pin_fsel = PWDATA[3:0];
        `ACS_OFF_INT:      next_int_ctl  = PWDATA[2:0];
        default:           next_int_ctl  = int_ctl;
      endcase
    end
    if (conv_done) begin
      next_int_ctl[`ACS_INT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_a   <= acs_pkg::ctrl_a_t'(`ACS_CTRL_RST);
      ctrl_b   <= acs_pkg::ctrl_b_t'(`ACS_CTRL_RST);
      pin_fsel <= `ACS_PIN_RST;
      int_ctl  <= 3'h0;
    end else begin
      ctrl_a   <= next_ctrl_a;
      ctrl_b   <= next_ctrl_b;
      pin_fsel <= next_pin_fsel;
      int_ctl  <= next_int_ctl;
    end
  end

  // ----------------------------------------------------------------
  // apb read and ready
  // ----------------------------------------------------------------
  // one wait cycle: data and ready are prepared in the first access cycle
  always_comb begin
    next_pready  = PSEL && PENABLE && !PREADY;
    next_pslverr = next_pready && !mapped(PADDR);
    next_prdata  = 32'h0;
    if (next_pready && !PWRITE) begin
      unique case (PADDR[7:0])
        `ACS_OFF_CTRL_A:   next_prdata = {24'h0, ctrl_a.start, busy, ctrl_a[5:0]};
        `ACS_OFF_CTRL_B:   next_prdata = {24'h0, ctrl_b};
        `ACS_OFF_RES_LO:   next_prdata = {24'h0, res_pair[7:0]};
        `ACS_OFF_RES_HI:   next_prdata = {24'h0, res_pair[15:8]};
        `ACS_OFF_PIN_FSEL: next_prdata = {28'h0, pin_fsel};
        `ACS_OFF_INT:      next_prdata = {29'h0, int_ctl};
        default:           next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA  <= 32'h0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // start edge is armed by a high level, pending after the fall,
  // and launched on the next converter clock strobe
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_armed  = armed;
    next_pend   = pend;
    next_result = result;
    conv_done   = 1'b0;
    if (ctrl_a.start || !ctrl_a.enable) begin
      next_state = acs_pkg::ACS_IDLE;
      next_cnt   = 4'h0;
      next_pend  = 1'b0;
      next_armed = ctrl_a.start;
    end else begin
      if (armed) begin
        next_pend  = 1'b1;
        next_armed = 1'b0;
      end
      unique case (state)
        acs_pkg::ACS_IDLE: begin
          if (pend && tick) begin
            next_state = acs_pkg::ACS_SAMPLE;
            next_pend  = 1'b0;
            next_cnt   = 4'h0;
          end
        end
        acs_pkg::ACS_SAMPLE: begin
          if (tick) begin
            if (cnt == `ACS_SAMPLE_CLKS - 4'h1) begin
              next_state = acs_pkg::ACS_CONVERT;
              next_cnt   = 4'h0;
            end else begin
              next_cnt = cnt + 4'h1;
            end
          end
        end
        acs_pkg::ACS_CONVERT: begin
          if (tick) begin
            if (cnt == `ACS_CONV_CLKS - 4'h1) begin
              next_state  = acs_pkg::ACS_IDLE;
              next_cnt    = 4'h0;
              next_result = ADC_DATA;
              conv_done   = 1'b1;
            end else begin
              next_cnt = cnt + 4'h1;
            end
          end
        end
        default: next_state = acs_pkg::ACS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state  <= acs_pkg::ACS_IDLE;
      cnt    <= 4'h0;
      armed  <= 1'b0;
      pend   <= 1'b0;
      busy   <= 1'b0;
      result <= 12'h000;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      armed  <= next_armed;
      pend   <= next_pend;
      busy   <= (next_state != acs_pkg::ACS_IDLE);
      result <= next_result;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs toward core, pins and interrupt
  // ----------------------------------------------------------------
  assign ADC_CLK_TICK = tick;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ADC_PWR     <= 1'b0;
      ADC_RST     <= 1'b0;
      ADC_SAMPLE  <= 1'b0;
      ADC_CONVERT <= 1'b0;
      REF_SEL     <= 3'h0;
      EXT_SEL     <= 4'h0;
      INT_SEL     <= 4'h0;
      PIN_ANALOG  <= 4'h0;
      PIN_PULL_EN <= 4'h0;
      PIN_OE      <= 4'h0;
      IRQ         <= 1'b0;
    end else begin
      ADC_PWR     <= ctrl_a.enable;
      ADC_RST     <= ctrl_a.start;
      ADC_SAMPLE  <= (next_state == acs_pkg::ACS_SAMPLE);
      ADC_CONVERT <= (next_state == acs_pkg::ACS_CONVERT);
      REF_SEL     <= route.ref_sel;
      EXT_SEL     <= route.ext_sel;
      INT_SEL     <= route.int_sel;
      PIN_ANALOG  <= pin_fsel;
      PIN_PULL_EN <= PIN_PULL_REQ & ~pin_fsel;
      PIN_OE      <= PIN_OE_REQ & ~pin_fsel;
      IRQ         <= int_ctl[`ACS_INT_FLAG] && int_ctl[`ACS_INT_EN] &&
                     int_ctl[`ACS_INT_GEN];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  logic [3:0] ticks_seen;
  always_ff @(posedge CLK) begin
    if (RST || state == acs_pkg::ACS_IDLE) begin
      ticks_seen <= 4'h0;
    end else if (tick) begin
      ticks_seen <= ticks_seen + 4'h1;
    end
  end

  a_launch_needs_fall: assert property (
    (state == acs_pkg::ACS_IDLE && next_state == acs_pkg::ACS_SAMPLE) |-> pend && !ctrl_a.start
  ) else $error("conversion launched without a start fall");
  a_start_holds_reset: assert property (
    ctrl_a.start |=> state == acs_pkg::ACS_IDLE && ADC_RST
  ) else $error("conversion running while start held high");
  a_busy_tracks_run: assert property (
    $rose(busy) |-> $past(pend) && $past(tick)
  ) else $error("busy flag rose without a pending launch");
  a_busy_clears_done: assert property (
    conv_done |=> !busy ##0 int_ctl[`ACS_INT_FLAG]
  ) else $error("busy or request flag wrong after completion");
  a_irq_gated: assert property (
    !(int_ctl[`ACS_INT_EN] && int_ctl[`ACS_INT_GEN]) |=> !IRQ
  ) else $error("interrupt raised while disabled");
  a_conv_sixteen: assert property (
    conv_done |-> ticks_seen == 4'hF && cnt == `ACS_CONV_CLKS - 4'h1
  ) else $error("conversion length is not sixteen clocks");
  a_disabled_idle: assert property (
    !ctrl_a.enable |=> state == acs_pkg::ACS_IDLE && !ADC_PWR
  ) else $error("converter active while disabled");
  a_result_held: assert property (
    !ctrl_a.enable |=> $stable(result)
  ) else $error("result changed while disabled");
  a_ext_floating: assert property (
    (ctrl_b.in_sel == 3'h0 && ctrl_a.chan > 4'h3) |=> EXT_SEL == 4'h0
  ) else $error("external pin connected for floating channel");
  a_dac_route: assert property (
    ctrl_b.in_sel == 3'h4 |=> INT_SEL == 4'h8 && EXT_SEL == 4'h0
  ) else $error("dac output not routed");
  a_ref_supply: assert property (
    ctrl_b.ref_sel == 2'h1 |=> REF_SEL == 3'h2
  ) else $error("supply reference not selected");
  a_pull_removed: assert property (
    ##1 (PIN_PULL_EN & $past(pin_fsel)) == 4'h0
  ) else $error("pull-high left on analog pin");

  c_conv_done: cover property (conv_done);
  c_irq_raised: cover property ($rose(IRQ));
  c_abort_start: cover property (state == acs_pkg::ACS_CONVERT && ctrl_a.start);
  c_slow_clock: cover property (conv_done && ctrl_b.clk_sel == 3'h7);
endmodule

// [tb/acs_core_model.sv]
// behavioural analog core: returns a set code while converting, noise otherwise
`timescale 1ns/1ps
module acs_core_model (
  input  wire logic        clk,    // system clock
  input  wire logic        pwr,    // analog power
  input  wire logic        conv,   // converting phase
  input  wire logic [11:0] level,  // code the input voltage maps to
  output logic      [11:0] data    // result toward the sequencer
);
  logic [11:0] noise = 12'h5A5;

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  // unpowered or idle core gives a pattern that flips every cycle
  always_ff @(posedge clk) begin
    noise <= ~noise;
  end

  assign data = (pwr && conv) ? level : noise;
endmodule

// [tb/acs_top_tb.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "acs_params.svh"
module acs_top_tb;
  logic        CLK = 1'b0, RST = 1'b1;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic        PREADY, PSLVERR, ADC_PWR, ADC_RST, ADC_CLK_TICK;
  logic        ADC_SAMPLE, ADC_CONVERT, IRQ;
  logic [11:0] ADC_DATA, level = 12'hA5C;
  logic [2:0]  REF_SEL;
  logic [3:0]  EXT_SEL, INT_SEL, PIN_ANALOG, PIN_PULL_EN, PIN_OE;
  logic [3:0]  PIN_PULL_REQ = 4'hC, PIN_OE_REQ = 4'h3;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0, cmp_count = 0, n, s, c;

  // ----------------------------------------
  // clock, design and analog core
  // ----------------------------------------
  always #12.5 CLK = ~CLK;

  acs_top dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_DATA(ADC_DATA),
    .ADC_PWR(ADC_PWR), .ADC_RST(ADC_RST), .ADC_CLK_TICK(ADC_CLK_TICK),
    .ADC_SAMPLE(ADC_SAMPLE), .ADC_CONVERT(ADC_CONVERT), .REF_SEL(REF_SEL),
    .EXT_SEL(EXT_SEL), .INT_SEL(INT_SEL), .PIN_PULL_REQ(PIN_PULL_REQ),
    .PIN_OE_REQ(PIN_OE_REQ), .PIN_ANALOG(PIN_ANALOG),
    .PIN_PULL_EN(PIN_PULL_EN), .PIN_OE(PIN_OE), .IRQ(IRQ));

  acs_core_model core (.clk(CLK), .pwr(ADC_PWR), .conv(ADC_CONVERT),
    .level(level), .data(ADC_DATA));

  // ----------------------------------------
  // helper tasks
  // ----------------------------------------
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (k >= 50) chk(32'h0, 32'h1);
  endtask

  task ca(input logic st, input logic en, input logic ju, input logic [3:0] ch);
    apb(1'b1, `ACS_OFF_CTRL_A, {24'h0, st, 1'b0, en, ju, ch});
  endtask

  // full conversion; counts sampling and converting cycles
  task run_conv(input logic [2:0] code, input logic ju);
    apb(1'b1, `ACS_OFF_CTRL_B, {29'h0, code});
    ca(1'b1, 1'b1, ju, 4'h0);
    repeat (2) @(posedge CLK);
    chk(ADC_RST, 1'b1);
    ca(1'b0, 1'b1, ju, 4'h0);
    s = 0; c = 0; n = 0;
    while (n < 5000 && !(c > 0 && ADC_SAMPLE !== 1'b1 && ADC_CONVERT !== 1'b1)) begin
      @(posedge CLK);
      n++;
      s += (ADC_SAMPLE === 1'b1);
      c += (ADC_CONVERT === 1'b1);
    end
    chk(s, 4 << code);
    chk(c, 12 << code);
    apb(1'b0, `ACS_OFF_CTRL_A, 32'h0);
    chk(rd[6], 1'b0);
  endtask

  task report_and_stop;
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #(25 * 60000);
    err_count++;
    report_and_stop;
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    apb(1'b0, `ACS_OFF_CTRL_A, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test reset and unmapped done");
    // power up, then settle before any start
    ca(1'b0, 1'b1, 1'b0, 4'h0);
    repeat (20) @(posedge CLK);
    chk(ADC_PWR, 1'b1);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `ACS_OFF_CTRL_B, k);
      repeat (2) @(posedge CLK);
      n = 0;
      while (ADC_CLK_TICK !== 1'b1 && n < 300) begin
        @(posedge CLK);
        n++;
      end
      n = 0;
      do begin
        @(posedge CLK);
        n++;
      end while (ADC_CLK_TICK !== 1'b1 && n < 300);
      chk(n, 1 << k);
    end
    $display("test divider done");
    // a low write with no high before it must not launch
    apb(1'b1, `ACS_OFF_CTRL_B, 32'h0);
    ca(1'b0, 1'b1, 1'b0, 4'h0);
    s = 0;
    repeat (40) begin
      @(posedge CLK);
      s += (ADC_SAMPLE === 1'b1);
    end
    chk(s, 0);
    apb(1'b1, `ACS_OFF_INT, 32'h6);
    run_conv(3'h5, 1'b0);
    @(posedge CLK);
    chk(IRQ, 1'b1);
    apb(1'b0, `ACS_OFF_RES_HI, 32'h0);
    chk(rd, 32'hA5);
    apb(1'b0, `ACS_OFF_RES_LO, 32'h0);
    chk(rd, 32'hC0);
    apb(1'b1, `ACS_OFF_INT, 32'h6);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0);
    apb(1'b1, `ACS_OFF_INT, 32'h2);
    run_conv(3'h7, 1'b1);
    repeat (2) @(posedge CLK);
    chk(IRQ, 1'b0);
    apb(1'b0, `ACS_OFF_INT, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, `ACS_OFF_INT, 32'h0);
    apb(1'b0, `ACS_OFF_RES_HI, 32'h0);
    chk(rd, 32'h0A);
    apb(1'b0, `ACS_OFF_RES_LO, 32'h0);
    chk(rd, 32'h5C);
    $display("test conversion done");
    // disabled converter keeps its result
    ca(1'b0, 1'b0, 1'b1, 4'h0);
    level <= 12'h123;
    repeat (2) @(posedge CLK);
    chk(ADC_PWR, 1'b0);
    ca(1'b1, 1'b0, 1'b1, 4'h0);
    ca(1'b0, 1'b0, 1'b1, 4'h0);
    repeat (80) @(posedge CLK);
    apb(1'b0, `ACS_OFF_RES_HI, 32'h0);
    chk(rd, 32'h0A);
    apb(1'b0, `ACS_OFF_RES_LO, 32'h0);
    chk(rd, 32'h5C);
    $display("test disable done");
    // reference decode
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `ACS_OFF_CTRL_B, r << 3);
      repeat (2) @(posedge CLK);
      chk(REF_SEL, (r == 1) ? 3'h2 : (r == 2) ? 3'h4 : 3'h1);
    end
    // source and channel; external source is set before a low channel
    for (int ch = 0; ch < 16; ch++) begin
      apb(1'b1, `ACS_OFF_CTRL_B, 32'h0);
      ca(1'b0, 1'b1, 1'b0, ch);
      for (int sr = 0; sr < 8; sr++) begin
        if (ch >= 4 || sr == 0 || sr > 4) begin
          apb(1'b1, `ACS_OFF_CTRL_B, sr << 5);
          repeat (2) @(posedge CLK);
          chk(EXT_SEL, ((sr == 0 || sr > 4) && ch < 4) ? 4'h1 << ch : 4'h0);
          chk(INT_SEL, (sr >= 1 && sr <= 4) ? 4'h1 << (sr - 1) : 4'h0);
        end
      end
    end
    $display("test routing done");
    // analog pin role drops pull-high and driver
    for (int f = 0; f < 16; f += 5) begin
      apb(1'b1, `ACS_OFF_PIN_FSEL, f);
      repeat (2) @(posedge CLK);
      chk(PIN_ANALOG, f);
      chk(PIN_PULL_EN, (f[3:0] ^ 4'hF) & 4'hC);
      chk(PIN_OE, (f[3:0] ^ 4'hF) & 4'h3);
    end
    $display("test pins done");
    // busy during a slow conversion, then abort by start high
    apb(1'b1, `ACS_OFF_CTRL_B, 32'h5);
    ca(1'b1, 1'b1, 1'b0, 4'h0);
    ca(1'b0, 1'b1, 1'b0, 4'h0);
    n = 0;
    while (ADC_CONVERT !== 1'b1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
    apb(1'b0, `ACS_OFF_CTRL_A, 32'h0);
    chk(rd[6], 1'b1);
    ca(1'b1, 1'b1, 1'b0, 4'h0);
    repeat (2) @(posedge CLK);
    chk(ADC_SAMPLE | ADC_CONVERT, 1'b0);
    apb(1'b0, `ACS_OFF_CTRL_A, 32'h0);
    chk(rd[6], 1'b0);
    apb(1'b0, `ACS_OFF_INT, 32'h0);
    chk(rd[0], 1'b0);
    $display("test abort done");
    report_and_stop;
  end
endmodule
